/* File: inc/hti_pkg.sv */
// Types shared by the sensor command interface modules.
// Assumes nothing beyond a SystemVerilog compiler.
package hti_pkg;

	// ****************************************************************
	// Bus engine states, one-hot
	// ****************************************************************
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_ADDR = 8'h02,
		ST_RX = 8'h04,
		ST_ACK = 8'h08,
		ST_TX = 8'h10,
		ST_MACK = 8'h20,
		ST_STRETCH = 8'h40,
		ST_RESET = 8'h80
	} hti_state_t;

	// Source of the next read payload
	typedef enum logic [2:0] {
		RD_NONE = 3'h1,
		RD_MEAS = 3'h2,
		RD_ID = 3'h4
	} hti_rdsrc_t;

	// ****************************************************************
	// Module state records
	// ****************************************************************
	typedef struct packed {
		logic scl_s1;
		logic scl_s2;
		logic scl_s3;
		logic sda_s1;
		logic sda_s2;
		logic sda_s3;
		hti_state_t st;
		hti_state_t ack_then;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic cmd_lo;
		logic [7:0] cmd_hi;
		logic [2:0] tx_idx;
		logic [7:0] tx_sh;
		logic mack_ok;
		hti_rdsrc_t rd_src;
		logic [15:0] srst_cnt;
		logic meas_start;
		logic cmd_stretch;
		logic cmd_hfirst;
		logic calib_reload;
		logic sda_oe;
		logic scl_oe;
		logic drv_lvl;
		logic dev_idle;
	} hti_main_t;

	typedef struct packed {
		logic busy;
		logic [23:0] cnt;
		logic stretch;
		logic hfirst;
		logic [15:0] hum;
		logic [15:0] temp;
	} hti_meas_t;

endpackage

/* File: inc/hti_regs.svh */
// Constants of the humidity sensor command interface: address, commands, CRC, timing.
// Assumes a 100 MHz system clock; included by bare name from the modules.
`ifndef HTI_REGS_SVH
`define HTI_REGS_SVH

// ****************************************************************
// Bus address and command codes
// ****************************************************************
`define HTI_DEV_ADDR 7'h70
`define HTI_CMD_ST_TF 16'h7CA2
`define HTI_CMD_ST_HF 16'h5C24
`define HTI_CMD_NS_TF 16'h7866
`define HTI_CMD_NS_HF 16'h58E0
`define HTI_CMD_SRST 16'h805D
`define HTI_CMD_ID 16'hEFC8

// ****************************************************************
// Checksum and identifier layout
// ****************************************************************
`define HTI_CRC_POLY 8'h31
`define HTI_CRC_INIT 8'hFF
`define HTI_ID_CODE_POS 0
`define HTI_ID_VARY_POS 6
`define HTI_MEAS_BYTES 3'h6
`define HTI_ID_BYTES 3'h3

// ****************************************************************
// Timing, times in ns as printed, counts derived from the clock
// ****************************************************************
`define HTI_CLK_PERIOD_NS 10
`define HTI_SRST_TIME_NS 230000
`define HTI_MEAS_TIME_NS 14400000
`define HTI_SRST_CYCLES (`HTI_SRST_TIME_NS / `HTI_CLK_PERIOD_NS)
`define HTI_MEAS_CYCLES (`HTI_MEAS_TIME_NS / `HTI_CLK_PERIOD_NS)

`endif

/* File: sim/hti_mst_model.sv */
// Bus master model: START, STOP and byte transfers on an 80 ns base tick.
// Assumes the bench forms wired-AND bus levels from every party's pull-down.
`timescale 1ns/1ps
module hti_mst_model
(
	input wire logic lclk,
	input wire logic scl_w,
	input wire logic sda_w,
	output logic scl_pull,
	output logic sda_pull
);
	// ********************
	// Bus phases
	// ********************
	// Eight ticks a quarter, plus one: a 2.64 us bus clock, under 400 kHz
	localparam int Q = 8;
	int stretch_ticks;

	// Both lines released, the pull-ups hold them high
	initial
	begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
		stretch_ticks = 0;
	end

	task automatic tk(input int n);
		repeat (n) @(posedge lclk);
	endtask

	// One bit: data set while SCL is low, sampled in the high phase
	task automatic bit_io(input logic b, output logic r);
		int n;
		n = 0;
		tk(Q);
		sda_pull <= ~b;
		tk(Q);
		scl_pull <= 1'b0;
		tk(1);
		// Target may stretch; a bound keeps a stuck line from hanging us
		while (scl_w !== 1'b1 && n < 20000)
		begin
			tk(1);
			n++;
		end
		stretch_ticks += n;
		tk(Q);
		r = sda_w;
		tk(Q);
		scl_pull <= 1'b1;
	endtask

	// Byte out or in; last is the ninth bit (1 releases, 0 acknowledges)
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
		output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(d[i], r);
			q[i] = r;
		end
		bit_io(last, r);
		ack = ~r;
	endtask

	// Start from idle or as a repeated start in place of a stop
	task automatic start();
		sda_pull <= 1'b0;
		tk(Q);
		scl_pull <= 1'b0;
		tk(2 * Q);
		sda_pull <= 1'b1;
		tk(2 * Q);
		scl_pull <= 1'b1;
	endtask

	// Data rises while the clock is high
	task automatic stop();
		tk(Q);
		sda_pull <= 1'b1;
		tk(Q);
		scl_pull <= 1'b0;
		tk(2 * Q);
		sda_pull <= 1'b0;
		tk(2 * Q);
	endtask
endmodule

/* File: sim/testbench.sv */
// Self-checking bench for the sensor's two-wire target: ID, measurements, refusals, reset.
// Assumes the master model and the design sources are compiled before it.
`timescale 1ns/1ps
module testbench
	import hti_pkg::*;
;
	// Short conversion and reset waits keep the run near a millisecond
	localparam int MEAS = 5000;
	localparam int SRST = 50;
	localparam int FRZ = 100;
	localparam logic [9:0] VARY = 10'h2A5; // Arbitrary value
	localparam logic [5:0] CODE = 6'h05; // Arbitrary value
	logic sys_clk = 1'b0;
	logic lclk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic [15:0] hum_w = 16'h0000;
	logic [15:0] temp_w = 16'h0000;
	logic scl_o, scl_oe, sda_o, sda_oe, meas_busy, dev_idle, calib_reload;
	logic scl_pull, sda_pull, scl_w, sda_w;
	logic [7:0] exp_q[$];
	int mismatches = 0;
	int compares = 0;
	int busy_run = 0;
	int busy_len = 0;
	int reloads = 0;
	logic [15:0] cmds[4] = '{16'h7CA2, 16'h5C24, 16'h7866, 16'h58E0};
	int rdn[4] = '{2, 3, 6, 2};

	// ********************
	// Clocks and wiring
	// ********************
	always #5 sys_clk = ~sys_clk;

	// Base tick offset so its edges never meet the system clock's
	initial
	begin
		#3;
		forever #40 lclk = ~lclk;
	end

	// Open-drain lines: low while anyone pulls
	assign scl_w = (scl_oe ? scl_o : 1'b1) & ~scl_pull;
	assign sda_w = (sda_oe ? sda_o : 1'b1) & ~sda_pull;

	hti_mst_model mst (.lclk(lclk), .scl_w(scl_w), .sda_w(sda_w), .scl_pull(scl_pull),
		.sda_pull(sda_pull));

	hti_i2c_target #(.MEAS_CYCLES(MEAS), .SRST_CYCLES(SRST), .ID_VARY(VARY),
		.ID_CODE(CODE)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
		.scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe(sda_oe), .raw_humidity_word(hum_w), .raw_temperature_word(temp_w),
		.meas_busy(meas_busy), .dev_idle(dev_idle), .calib_reload(calib_reload));

	// Conversion length and reload pulses, counted in system cycles
	always @(posedge sys_clk)
	begin
		if (meas_busy === 1'b1)
			busy_run <= busy_run + 1;
		else if (busy_run != 0)
		begin
			busy_len <= busy_run;
			busy_run <= 0;
		end
		if (calib_reload === 1'b1)
			reloads <= reloads + 1;
	end

	// ********************
	// Reference model and checks
	// ********************
	function automatic logic [7:0] crc8(input logic [15:0] w);
		logic [7:0] c;
		c = 8'hFF;
		for (int i = 15; i >= 0; i--)
			c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ 8'h31) : {c[6:0], 1'b0};
		return c;
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Two words, each high byte first and followed by its checksum
	task automatic push(input logic [15:0] w1, input logic [15:0] w2);
		exp_q = {w1[15:8], w1[7:0], crc8(w1), w2[15:8], w2[7:0], crc8(w2)};
	endtask

	task automatic wr(input logic [7:0] d, input logic ack);
		logic [7:0] q;
		logic a;
		mst.xfer(d, 1'b1, q, a);
		chk(a, ack);
	endtask

	task automatic hdr(input logic rw, input logic [6:0] a, input logic ack);
		mst.start();
		wr({a, rw}, ack);
	endtask

	// Read n bytes, refusing the last one, then confirm the target let go
	task automatic rd(input int n);
		logic [7:0] q;
		logic a;
		for (int i = 0; i < n; i++)
		begin
			mst.xfer(8'hFF, i == n - 1, q, a);
			chk(q, exp_q.pop_front());
		end
		exp_q.delete();
		mst.tk(8);
		chk(sda_oe, 1'b0);
		mst.stop();
	endtask

	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ********************
	// Sequence
	// ********************
	initial
	begin
		logic [15:0] h, t;
		h = 16'($urandom(4));
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk(dev_idle, 1'b1);
		hdr(1'b0, 7'h71, 1'b0);
		mst.stop();
		hdr(1'b0, 7'h70, 1'b1);
		wr(8'hEF, 1'b1);
		wr(8'hC8, 1'b1);
		hdr(1'b1, 7'h70, 1'b1);
		push({VARY, CODE}, 16'h0000);
		rd(3);
		// Every measurement code, random results, mixed read lengths
		foreach (cmds[i])
		begin
			h = 16'($urandom());
			// A known temperature word drives the checksum example through the design
			t = (i == 0) ? 16'hBEEF : 16'($urandom());
			@(posedge sys_clk);
			hum_w <= h;
			temp_w <= t;
			hdr(1'b0, 7'h70, 1'b1);
			wr(cmds[i][15:8], 1'b1);
			wr(cmds[i][7:0], 1'b1);
			mst.stop();
			chk(meas_busy, 1'b1);
			mst.stretch_ticks = 0;
			if (i >= 2)
			begin
				hdr(1'b1, 7'h70, 1'b0);
				mst.stop();
				// Freeze mid-conversion: the run must grow by exactly the frozen cycles
				@(posedge sys_clk);
				clk_en <= 1'b0;
				repeat (FRZ) @(posedge sys_clk);
				clk_en <= 1'b1;
				// Bus stays quiet until the conversion is over; the watchdog bounds this
				while (meas_busy !== 1'b0)
					@(posedge sys_clk);
			end
			hdr(1'b1, 7'h70, 1'b1);
			if (i % 2 == 1)
				push(h, t);
			else
				push(t, h);
			rd(rdn[i]);
			chk(mst.stretch_ticks > 0, i < 2);
			chk(16'(busy_len), 16'(MEAS + ((i >= 2) ? FRZ : 0)));
		end
		hdr(1'b0, 7'h70, 1'b1);
		wr(8'h12, 1'b1);
		wr(8'h34, 1'b0);
		mst.stop();
		hdr(1'b0, 7'h70, 1'b1);
		wr(8'h80, 1'b1);
		wr(8'h5D, 1'b1);
		repeat (8) @(posedge sys_clk);
		chk(dev_idle, 1'b0);
		chk(16'(reloads), 16'h0001);
		repeat (SRST) @(posedge sys_clk);
		chk(dev_idle, 1'b1);
		mst.stop();
		hdr(1'b1, 7'h70, 1'b0);
		mst.stop();
		chk(dev_idle, 1'b1);
		test_done();
	end

	// Watchdog: the sequence needs about 1.2 ms, so 2 ms means a hang
	initial
	begin
		#2000000;
		mismatches++;
		test_done();
	end
endmodule

/* File: src/hti_crc8.sv */
// Checksum over one 16-bit word, most significant bit first.
// Purely combinational; the caller samples the result on its own clock.
`timescale 1ns/1ps
`include "hti_regs.svh"
module hti_crc8
	import hti_pkg::*;
(
	input wire logic [15:0] word,
	output logic [7:0] crc
);

	// ****************************************************************
	// Bitwise shift register, unrolled by the loop
	// ****************************************************************
	always_comb
	begin
		logic [7:0] c;
		c = `HTI_CRC_INIT;
		for (int i = 15; i >= 0; i--)
		begin
			if (c[7] ^ word[i])
				c = {c[6:0], 1'b0} ^ `HTI_CRC_POLY;
			else
				c = {c[6:0], 1'b0};
		end
		crc = c;
	end

endmodule

/* File: src/hti_i2c_target.sv */
// Two-wire target for the humidity sensor: command decode, results, checksum, soft reset.
// Assumes open-drain pads outside; scl_i and sda_i are asynchronous pin levels.
`timescale 1ns/1ps
`include "hti_regs.svh"
// Behaviour
// - Answer only address 0x70; other addresses are ignored.
// - Idle device accepts new commands.
// - Not measuring and not on the bus means idle.
// - Every transfer starts with START; repeated START replaces STOP.
// - Write header acknowledged by pulling data low after eighth clock fall.
// - Both command bytes acknowledged; valid measurement command starts conversion. The code acks the second byte only for a known command.
// - Four measurement codes select stretching and result order.
// - Result order follows the command that started the conversion.
// - During non-stretch conversion, no header is acknowledged.
// - During stretch conversion, read header acked, clock held until done.
// - Read sends word, CRC, word, CRC, high byte first.
// - Sending stops and data is released after a master NACK.
// - Soft reset command clears state machines and reloads calibration.
// - ID command makes next read return identifier plus CRC.
// - Identifier: part-varying bits 15:6, product code bits 5:0.
// - CRC-8 polynomial 0x31, init 0xFF, no reflection, no final XOR.
// - Each CRC covers the two data bytes just before it.
// - Results are 16-bit unsigned compensated words.
// - Idle within 230 us after soft reset acknowledge.
// - Conversion completes within 14.4 ms.
module hti_i2c_target
	import hti_pkg::*;
#(
	parameter int MEAS_CYCLES = `HTI_MEAS_CYCLES,
	parameter int SRST_CYCLES = `HTI_SRST_CYCLES,
	parameter logic [9:0] ID_VARY = 10'h000, // Arbitrary value
	parameter logic [5:0] ID_CODE = 6'h05 // Arbitrary value
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic [15:0] raw_humidity_word,
	input wire logic [15:0] raw_temperature_word,
	output logic meas_busy,
	output logic dev_idle,
	output logic calib_reload
);

	hti_main_t q;
	hti_main_t d;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic m_busy;
	logic m_stretch;
	logic m_hfirst;
	logic [15:0] m_hum;
	logic [15:0] m_temp;
	logic [15:0] cmd;
	logic [2:0] sel_idx;
	logic [2:0] part;
	logic [2:0] nbytes;
	logic [15:0] crc_word;
	logic [7:0] crc_val;
	logic [7:0] sel_byte;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	hti_meas #(
		.MEAS_CYCLES(MEAS_CYCLES)
	) u_meas (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.start(q.meas_start),
		.start_stretch(q.cmd_stretch),
		.start_hfirst(q.cmd_hfirst),
		.abort(q.calib_reload),
		.raw_humidity_word(raw_humidity_word),
		.raw_temperature_word(raw_temperature_word),
		.busy(m_busy),
		.stretch(m_stretch),
		.hfirst(m_hfirst),
		.hum(m_hum),
		.temp(m_temp)
	);

	hti_crc8 u_crc (
		.word(crc_word),
		.crc(crc_val)
	);

	// Bus events from the synchronised levels; first flops are never read here
	assign scl_rise = q.scl_s2 & ~q.scl_s3;
	assign scl_fall = ~q.scl_s2 & q.scl_s3;
	assign start_c = q.scl_s2 & q.scl_s3 & ~q.sda_s2 & q.sda_s3;
	assign stop_c = q.scl_s2 & q.scl_s3 & q.sda_s2 & ~q.sda_s3;
	assign cmd = {q.cmd_hi, q.sh};

	// ****************************************************************
	// Payload selection: next byte index, its word and checksum
	// ****************************************************************
	always_comb
	begin
		sel_idx = (q.st == ST_MACK) ? q.tx_idx + 3'h1 : 3'h0;
		part = (sel_idx >= 3'h3) ? sel_idx - 3'h3 : sel_idx;
		nbytes = (q.rd_src == RD_ID) ? `HTI_ID_BYTES : `HTI_MEAS_BYTES;
		if (q.rd_src == RD_ID)
			crc_word = {ID_VARY, ID_CODE};
		else if ((sel_idx < 3'h3) == m_hfirst)
			crc_word = m_hum;
		else
			crc_word = m_temp;
		unique case (part)
			3'h0: sel_byte = crc_word[15:8];
			3'h1: sel_byte = crc_word[7:0];
			default: sel_byte = crc_val;
		endcase
	end

	// ****************************************************************
	// Bus engine
	// ****************************************************************
	always_comb
	begin
		d = q;
		d.meas_start = 1'b0;
		d.calib_reload = 1'b0;
		d.scl_s1 = scl_i;
		d.scl_s2 = q.scl_s1;
		d.scl_s3 = q.scl_s2;
		d.sda_s1 = sda_i;
		d.sda_s2 = q.sda_s1;
		d.sda_s3 = q.sda_s2;
		unique case (q.st)
			ST_IDLE:
			begin
				d.sda_oe = 1'b0;
			end
			ST_ADDR, ST_RX:
			begin
				if (scl_rise)
				begin
					d.sh = {q.sh[6:0], q.sda_s2};
					d.cnt = q.cnt + 4'h1;
				end
				else if (scl_fall && q.cnt == 4'h8)
				begin
					d.st = ST_IDLE;
					d.cnt = 4'h0;
					if (q.st == ST_ADDR)
					begin
						if (q.sh[7:1] != `HTI_DEV_ADDR)
							d.st = ST_IDLE;
						else if (q.sh[0] && m_busy && m_stretch)
							d.ack_then = ST_STRETCH;
						else if (q.sh[0] && !m_busy && q.rd_src != RD_NONE)
							d.ack_then = ST_TX;
						else if (!q.sh[0] && !m_busy)
							d.ack_then = ST_RX;
						else
							d.ack_then = ST_IDLE;
						d.cmd_lo = 1'b0;
						if (q.sh[7:1] == `HTI_DEV_ADDR && d.ack_then != ST_IDLE)
							d.st = ST_ACK;
					end
					else if (!q.cmd_lo)
					begin
						d.cmd_hi = q.sh;
						d.cmd_lo = 1'b1;
						d.ack_then = ST_RX;
						d.st = ST_ACK;
					end
					else
					begin
						d.st = ST_ACK;
						d.ack_then = ST_IDLE;
						unique case (cmd)
							`HTI_CMD_ST_TF, `HTI_CMD_ST_HF, `HTI_CMD_NS_TF, `HTI_CMD_NS_HF:
							begin
								d.meas_start = 1'b1;
								// Code bit 10 marks stretching and bit 13 temperature first; the codes are still matched whole
								d.cmd_stretch = (cmd == `HTI_CMD_ST_TF) || (cmd == `HTI_CMD_ST_HF);
								d.cmd_hfirst = (cmd == `HTI_CMD_ST_HF) || (cmd == `HTI_CMD_NS_HF);
								d.rd_src = RD_MEAS;
							end
							`HTI_CMD_ID: d.rd_src = RD_ID;
							`HTI_CMD_SRST: d.ack_then = ST_RESET;
							default: d.st = ST_IDLE;
						endcase
					end
					d.sda_oe = (d.st == ST_ACK);
				end
			end
			ST_ACK:
			begin
				if (scl_fall)
				begin
					d.st = q.ack_then;
					d.sda_oe = 1'b0;
					d.cnt = 4'h0;
					if (q.ack_then == ST_TX)
					begin
						d.tx_idx = 3'h0;
						d.tx_sh = sel_byte;
						d.sda_oe = ~sel_byte[7];
					end
					else if (q.ack_then == ST_STRETCH)
						d.scl_oe = 1'b1;
					else if (q.ack_then == ST_RESET)
					begin
						d.srst_cnt = 16'h0000;
						d.calib_reload = 1'b1;
						d.rd_src = RD_NONE;
					end
				end
			end
			ST_STRETCH:
			begin
				// Clock stays low until the conversion ends, then the first bit goes out
				if (!m_busy)
				begin
					d.scl_oe = 1'b0;
					d.st = ST_TX;
					d.tx_idx = 3'h0;
					d.tx_sh = sel_byte;
					d.sda_oe = ~sel_byte[7];
				end
			end
			ST_TX:
			begin
				if (scl_fall)
				begin
					if (q.cnt == 4'h7)
					begin
						d.sda_oe = 1'b0;
						d.st = ST_MACK;
					end
					else
					begin
						d.cnt = q.cnt + 4'h1;
						d.tx_sh = {q.tx_sh[6:0], 1'b0};
						d.sda_oe = ~q.tx_sh[6];
					end
				end
			end
			ST_MACK:
			begin
				if (scl_rise)
				begin
					d.mack_ok = ~q.sda_s2;
					if (q.sda_s2)
						d.st = ST_IDLE;
				end
				else if (scl_fall)
				begin
					d.cnt = 4'h0;
					if (q.mack_ok && sel_idx < nbytes)
					begin
						d.st = ST_TX;
						d.tx_idx = sel_idx;
						d.tx_sh = sel_byte;
						d.sda_oe = ~sel_byte[7];
					end
					else
						d.st = ST_IDLE;
				end
			end
			ST_RESET:
			begin
				// Bus is deaf until the reset time has run out
				if (q.srst_cnt == 16'(SRST_CYCLES - 1))
					d.st = ST_IDLE;
				else
					d.srst_cnt = q.srst_cnt + 16'h0001;
			end
		endcase
		// START or STOP abort any transfer, except while recovering from reset or stretching the clock
		if (q.st != ST_RESET && q.st != ST_STRETCH && (start_c || stop_c))
		begin
			d.st = start_c ? ST_ADDR : ST_IDLE;
			d.cnt = 4'h0;
			d.sda_oe = 1'b0;
		end
		d.dev_idle = (d.st == ST_IDLE) && !m_busy;
	end

	// Frozen while the clock enable is low
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q <= '0;
			q.scl_s1 <= 1'b1;
			q.scl_s2 <= 1'b1;
			q.scl_s3 <= 1'b1;
			q.sda_s1 <= 1'b1;
			q.sda_s2 <= 1'b1;
			q.sda_s3 <= 1'b1;
			q.st <= ST_IDLE;
			q.ack_then <= ST_IDLE;
			q.rd_src <= RD_NONE;
		end
		else if (clk_en)
			q <= d;
	end

	assign scl_o = q.drv_lvl;
	assign sda_o = q.drv_lvl;
	assign scl_oe = q.scl_oe;
	assign sda_oe = q.sda_oe;
	assign meas_busy = m_busy;
	assign dev_idle = q.dev_idle;
	assign calib_reload = q.calib_reload;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n || !clk_en);

	property p_addr_ack;
		(q.st == ST_ADDR && d.st == ST_ACK) |-> q.sh[7:1] == `HTI_DEV_ADDR;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("acked a foreign address");

	property p_busy_nack;
		(q.st == ST_ADDR && m_busy && !m_stretch) |-> d.st != ST_ACK;
	endproperty
	a_busy_nack: assert property (p_busy_nack) else $error("acked header while busy");

	property p_ack_drive;
		(q.st != ST_ACK && d.st == ST_ACK) |=> q.sda_oe throughout (q.st == ST_ACK)[*2];
	endproperty
	a_ack_drive: assert property (p_ack_drive) else $error("ack not driven");

	property p_stretch_rel;
		(q.st == ST_STRETCH && !m_busy) |=> !q.scl_oe && q.st == ST_TX;
	endproperty
	a_stretch_rel: assert property (p_stretch_rel) else $error("clock not released");

	property p_nack_stop;
		(q.st == ST_MACK && scl_rise && q.sda_s2) |=> !q.sda_oe ##1 !q.sda_oe;
	endproperty
	a_nack_stop: assert property (p_nack_stop) else $error("sent after nack");

	property p_crc_ex;
		crc_word == 16'hBEEF |-> crc_val == 8'h92;
	endproperty
	a_crc_ex: assert property (p_crc_ex) else $error("checksum wrong");

	property p_first_byte;
		(q.st == ST_ACK && scl_fall && q.ack_then == ST_TX && q.rd_src == RD_MEAS)
			|=> q.tx_sh == ($past(m_hfirst) ? m_hum[15:8] : m_temp[15:8]);
	endproperty
	a_first_byte: assert property (p_first_byte) else $error("wrong first byte");

	property p_srst;
		(q.st == ST_ACK && scl_fall && q.ack_then == ST_RESET) |=> q.calib_reload ##1 !q.calib_reload;
	endproperty
	a_srst: assert property (p_srst) else $error("reset pulse wrong");

	property p_srst_len;
		q.st == ST_RESET |-> q.srst_cnt < 16'(SRST_CYCLES);
	endproperty
	a_srst_len: assert property (p_srst_len) else $error("reset overran");

	property p_meas_start;
		(q.meas_start && !m_busy) |=> m_busy;
	endproperty
	a_meas_start: assert property (p_meas_start) else $error("conversion not started");

	c_stretch: cover property (q.st == ST_STRETCH ##1 q.st == ST_TX);
	c_id_read: cover property (q.rd_src == RD_ID && q.st == ST_TX);
	c_reset_done: cover property (q.st == ST_RESET ##1 q.st == ST_IDLE);

endmodule

/* File: src/hti_meas.sv */
// Measurement sequencer: times one combined conversion and latches both results.
// Assumes raw words come from logic on sys_clk and are valid at the end of the run.
`timescale 1ns/1ps
`include "hti_regs.svh"
module hti_meas
	import hti_pkg::*;
#(
	parameter int MEAS_CYCLES = `HTI_MEAS_CYCLES
)
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic start,
	input wire logic start_stretch,
	input wire logic start_hfirst,
	input wire logic abort,
	input wire logic [15:0] raw_humidity_word,
	input wire logic [15:0] raw_temperature_word,
	output logic busy,
	output logic stretch,
	output logic hfirst,
	output logic [15:0] hum,
	output logic [15:0] temp
);

	hti_meas_t q;
	hti_meas_t d;

	// ****************************************************************
	// Conversion timer
	// ****************************************************************
	always_comb
	begin
		d = q;
		if (abort)
			d.busy = 1'b0;
		else if (start && !q.busy)
		begin
			d.busy = 1'b1;
			d.cnt = '0;
			d.stretch = start_stretch;
			d.hfirst = start_hfirst;
		end
		else if (q.busy)
		begin
			if (q.cnt == 24'(MEAS_CYCLES - 1))
			begin
				d.busy = 1'b0;
				d.hum = raw_humidity_word;
				d.temp = raw_temperature_word;
			end
			else
				d.cnt = q.cnt + 24'h0001;
		end
	end

	// Frozen while the clock enable is low
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			q <= '0;
		else if (clk_en)
			q <= d;
	end

	assign busy = q.busy;
	assign stretch = q.stretch;
	assign hfirst = q.hfirst;
	assign hum = q.hum;
	assign temp = q.temp;

	// ****************************************************************
	// Checks
	// ****************************************************************
	property p_meas_len;
		@(posedge sys_clk) disable iff (!rst_n || !clk_en)
		q.busy |-> (q.cnt < 24'(MEAS_CYCLES));
	endproperty
	a_meas_len: assert property (p_meas_len) else $error("conversion overran its time");

endmodule
